// >>> pkg/adc_cal_consts.svh
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH
// register indices; the byte address is four times the index
`define IDX_PREV_GAIN_LOW 10'h00d
`define IDX_CFG           10'h00e
`define IDX_OFS_HIGH      10'h00f
`define IDX_OFS_LOW       10'h010
`define IDX_GAIN_HIGH     10'h011
`define IDX_GAIN_LOW      10'h012
`define IDX_GLOBAL_DC     10'h020
// reset values
`define RST_CFG           16'h0000
`define RST_HIGH_ZERO     16'h0000
`define RST_GAIN_HIGH     16'h8000
`define RST_LOW_BYTE      8'h00
`define RST_GLOBAL_DC     4'h0
// field positions
`define CFG_PHASE_MSB     15
`define CFG_PHASE_LSB     6
`define CFG_DCOFF_BIT     2
`define CFG_SEL_MSB       1
`define CFG_SEL_LSB       0
`define LOW_MSB           15
`define LOW_LSB           8
`define GDC_MSB           3
`define GDC_LSB           0
// bus lane split and word alignment
`define LANE1_MSB         15
`define LANE1_LSB         8
`define LANE0_MSB         7
`define LANE0_LSB         0
`define ALIGN_ZERO        2'h0
`endif

// >>> pkg/adc_cal_pkg.sv
package adc_cal_pkg;
  // which signal feeds the modulator
  typedef enum logic [1:0] {
    SEL_OWN_PAIR = 2'h0,
    SEL_SHORTED  = 2'h1,
    SEL_POS_TEST = 2'h2,
    SEL_NEG_TEST = 2'h3
  } input_sel_e;
  // channel configuration as seen by the datapath
  typedef struct packed {
    logic [9:0] phase;
    logic       dc_off;
    input_sel_e sel;
  } chan_cfg_s;
  // one 24-bit calibration word with its update pulse
  typedef struct packed {
    logic [23:0] word;
    logic        upd;
  } cal_word_s;
endpackage : adc_cal_pkg

// >>> hw/field_reg.sv
`timescale 1ns/1ps
`default_nettype none
// one writable field with a constant reset value
module field_reg #(
  parameter int unsigned  W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // write side
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  // stored value
  output logic      [W-1:0] q_ff
);
  // refuse a zero-width field
  if (W < 1) begin : g_bad_w
    $error("field_reg: width must be at least one");
  end
  // store on write, constant on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= RST;
    end else if (wr_en) begin
      q_ff <= wr_data;
    end
  end
endmodule : field_reg
`default_nettype wire

// >>> hw/cal_word_join.sv
`timescale 1ns/1ps
`default_nettype none
// joins a high half and a low byte into one registered 24-bit word
module cal_word_join
  import adc_cal_pkg::*;
#(
  parameter logic [23:0] RST = 24'h000000
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // halves from the register file
  input  wire logic [15:0] high,
  input  wire logic [7:0]  low,
  input  wire logic        wr_any,
  // joined word to the datapath
  output cal_word_s        word_ff
);
  logic wr_seen_ff;  // write seen at the commit edge, waits for the stored half

  // the halves are stored at the commit edge, so the pulse waits one edge
  // to land together with the word that it announces
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_seen_ff <= 1'b0;
    end else begin
      wr_seen_ff <= wr_any;
    end
  end

  // copy every cycle so a write to either half shows one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ff <= {RST, 1'b0};
    end else begin
      word_ff <= {high, low, wr_seen_ff};
    end
  end
endmodule : cal_word_join
`default_nettype wire

// >>> hw/adc_channel_cal_config_regs.sv
// How it works
// - phase delay, ten bits signed, cfg 15:6
// - reserved bits read zero, ignore writes
// - cfg bit 2 turns channel filter off
// - cfg 1:0 picks input or test signal
// - offset high holds offset bits 23:8
// - offset low 15:8 holds bits 7:0
// - gain high holds gain bits 23:8
// - gain low 15:8 holds bits 7:0
// - gain word unsigned, unity at midscale
// - gain high resets to unity value
// - cfg resets to all zero
// - previous channel gain low byte kept
// - global filter setting, four-bit field
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_consts.svh"
module adc_channel_cal_config_regs
  import adc_cal_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // channel configuration
  output chan_cfg_s              chan_cfg,
  output logic      [3:0]        global_dc_filter_setting,
  // calibration words
  output cal_word_s              chan_offset,
  output cal_word_s              chan_gain,
  output logic      [7:0]        prev_chan_gain_low
);
  // the highest index needs eight address bits
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("adc_channel_cal_config_regs: ADDR_W must be 8 to 32");
  end

  logic        pready_ff;    // answer flag, high for one access cycle
  logic        pslverr_ff;   // error flag sampled with the answer
  logic [31:0] prdata_ff;    // read data captured in setup
  logic [9:0]  idx;          // word index of the request
  logic        hit;          // request names a mapped word
  logic [15:0] rd_word;      // current content of the addressed word
  logic [15:0] wmerge;       // write data merged per byte lane
  logic        acc_wr;       // write committed at this edge
  logic        setup;        // first cycle of a transfer
  // stored fields
  logic [9:0]  phase_q;
  logic        dcoff_q;
  logic [1:0]  sel_q;
  logic [15:0] ofs_hi_q;
  logic [7:0]  ofs_lo_q;
  logic [15:0] gain_hi_q;
  logic [7:0]  gain_lo_q;
  logic [7:0]  prev_lo_q;
  logic [3:0]  gdc_q;
  // per-register write strobes
  logic        wr_cfg;
  logic        wr_ofs_hi;
  logic        wr_ofs_lo;
  logic        wr_gain_hi;
  logic        wr_gain_lo;
  logic        wr_prev;
  logic        wr_gdc;
  // reset image of the configuration word, sliced per field below
  localparam logic [15:0] CFG_RST = `RST_CFG;

  assign idx   = 10'(paddr[ADDR_W-1:2]);
  assign setup = psel && !penable;
  // a write lands only at the edge where the answer is seen
  assign acc_wr = psel && penable && pready_ff && pwrite && hit;

  // address decode; misaligned words count as unmapped
  always_comb begin
    hit     = 1'b0;
    rd_word = 16'h0000;
    if (paddr[1:0] == `ALIGN_ZERO) begin
      unique case (idx)
        `IDX_CFG: begin
          hit     = 1'b1;
          // bits 5:3 stay zero
          rd_word = {phase_q, 3'h0, dcoff_q, sel_q};
        end
        `IDX_OFS_HIGH: begin
          hit     = 1'b1;
          rd_word = ofs_hi_q;
        end
        `IDX_OFS_LOW: begin
          hit     = 1'b1;
          rd_word = {ofs_lo_q, 8'h00};
        end
        `IDX_GAIN_HIGH: begin
          hit     = 1'b1;
          rd_word = gain_hi_q;
        end
        `IDX_GAIN_LOW: begin
          hit     = 1'b1;
          rd_word = {gain_lo_q, 8'h00};
        end
        `IDX_PREV_GAIN_LOW: begin
          hit     = 1'b1;
          rd_word = {prev_lo_q, 8'h00};
        end
        `IDX_GLOBAL_DC: begin
          hit     = 1'b1;
          rd_word = {12'h000, gdc_q};
        end
        default: begin
          hit     = 1'b0;
        end
      endcase
    end
  end

  // byte lanes left unstrobed keep their current content
  always_comb begin
    wmerge = rd_word;
    if (pstrb[1]) begin
      wmerge[`LANE1_MSB:`LANE1_LSB] = pwdata[`LANE1_MSB:`LANE1_LSB];
    end
    if (pstrb[0]) begin
      wmerge[`LANE0_MSB:`LANE0_LSB] = pwdata[`LANE0_MSB:`LANE0_LSB];
    end
  end

  // write strobes per register
  assign wr_cfg     = acc_wr && (idx == `IDX_CFG);
  assign wr_ofs_hi  = acc_wr && (idx == `IDX_OFS_HIGH);
  assign wr_ofs_lo  = acc_wr && (idx == `IDX_OFS_LOW);
  assign wr_gain_hi = acc_wr && (idx == `IDX_GAIN_HIGH);
  assign wr_gain_lo = acc_wr && (idx == `IDX_GAIN_LOW);
  assign wr_prev    = acc_wr && (idx == `IDX_PREV_GAIN_LOW);
  assign wr_gdc     = acc_wr && (idx == `IDX_GLOBAL_DC);

  // answer one cycle after setup: a fixed zero-wait access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
    end
  end

  // unmapped or misaligned words answer with an error and no store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup && !hit;
    end
  end

  // read data taken in setup, zero outside the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_ff <= {16'h0000, rd_word};
    end else begin
      prdata_ff <= 32'h00000000;
    end
  end

  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata  = prdata_ff;

  // configuration fields, all zero after reset
  field_reg #(.W(10), .RST(CFG_RST[`CFG_PHASE_MSB:`CFG_PHASE_LSB])) u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_cfg),
    .wr_data (wmerge[`CFG_PHASE_MSB:`CFG_PHASE_LSB]),
    .q_ff    (phase_q)
  );
  field_reg #(.W(1), .RST(CFG_RST[`CFG_DCOFF_BIT])) u_dcoff (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_cfg),
    .wr_data (wmerge[`CFG_DCOFF_BIT]),
    .q_ff    (dcoff_q)
  );
  field_reg #(.W(2), .RST(CFG_RST[`CFG_SEL_MSB:`CFG_SEL_LSB])) u_sel (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_cfg),
    .wr_data (wmerge[`CFG_SEL_MSB:`CFG_SEL_LSB]),
    .q_ff    (sel_q)
  );
  // offset halves, two's complement as a whole
  field_reg #(.W(16), .RST(`RST_HIGH_ZERO)) u_ofs_hi (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ofs_hi),
    .wr_data (wmerge),
    .q_ff    (ofs_hi_q)
  );
  field_reg #(.W(8), .RST(`RST_LOW_BYTE)) u_ofs_lo (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_ofs_lo),
    .wr_data (wmerge[`LOW_MSB:`LOW_LSB]),
    .q_ff    (ofs_lo_q)
  );
  // gain halves; high half starts at unity
  field_reg #(.W(16), .RST(`RST_GAIN_HIGH)) u_gain_hi (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_gain_hi),
    .wr_data (wmerge),
    .q_ff    (gain_hi_q)
  );
  field_reg #(.W(8), .RST(`RST_LOW_BYTE)) u_gain_lo (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_gain_lo),
    .wr_data (wmerge[`LOW_MSB:`LOW_LSB]),
    .q_ff    (gain_lo_q)
  );
  // previous channel gain low byte
  field_reg #(.W(8), .RST(`RST_LOW_BYTE)) u_prev_lo (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_prev),
    .wr_data (wmerge[`LOW_MSB:`LOW_LSB]),
    .q_ff    (prev_lo_q)
  );
  // global filter setting that a channel follows unless turned off
  field_reg #(.W(4), .RST(`RST_GLOBAL_DC)) u_gdc (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_gdc),
    .wr_data (wmerge[`GDC_MSB:`GDC_LSB]),
    .q_ff    (gdc_q)
  );

  // joined words; a half-written pair is visible between the two writes
  cal_word_join #(.RST({`RST_HIGH_ZERO, `RST_LOW_BYTE})) u_ofs_word (
    .pclk    (pclk),
    .presetn (presetn),
    .high    (ofs_hi_q),
    .low     (ofs_lo_q),
    .wr_any  (wr_ofs_hi || wr_ofs_lo),
    .word_ff (chan_offset)
  );
  // unsigned gain, one step is 2^-24 of full span below 2.0
  cal_word_join #(.RST({`RST_GAIN_HIGH, `RST_LOW_BYTE})) u_gain_word (
    .pclk    (pclk),
    .presetn (presetn),
    .high    (gain_hi_q),
    .low     (gain_lo_q),
    .wr_any  (wr_gain_hi || wr_gain_lo),
    .word_ff (chan_gain)
  );

  // field outputs come straight from the field flops
  assign chan_cfg                 = {phase_q, dcoff_q, input_sel_e'(sel_q)};
  assign global_dc_filter_setting = gdc_q;
  assign prev_chan_gain_low       = prev_lo_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a full cfg write lands in the phase field
  phase_write_a: assert property (
    wr_cfg && pstrb[1:0] == 2'h3 |=> chan_cfg.phase == $past(pwdata[15:6]))
    else $error("phase field not written");
  // reserved cfg bits and upper half read zero
  cfg_rsvd_read_a: assert property (
    pready && !pwrite && !pslverr && $past(idx) == `IDX_CFG
    |-> prdata[5:3] == 3'h0 && prdata[31:16] == 16'h0000)
    else $error("reserved cfg bits not zero");
  // offset and gain low registers read zero in their low byte
  low_rsvd_read_a: assert property (
    pready && !pwrite && ($past(idx) == `IDX_OFS_LOW || $past(idx) == `IDX_GAIN_LOW)
    |-> prdata[7:0] == 8'h00)
    else $error("reserved low byte not zero");
  // filter-off bit follows lane zero
  dc_off_write_a: assert property (
    wr_cfg && pstrb[0] |=> chan_cfg.dc_off == $past(pwdata[2]))
    else $error("dc off bit not written");
  // input select follows lane zero
  input_sel_a: assert property (
    wr_cfg && pstrb[0] |=> chan_cfg.sel == $past(pwdata[1:0]))
    else $error("input select not written");
  // offset high reaches the joined word two edges later
  ofs_high_word_a: assert property (
    wr_ofs_hi && pstrb[1:0] == 2'h3 |-> ##2 chan_offset.word[23:8] == $past(pwdata[15:0], 2))
    else $error("offset high not joined");
  // offset low byte lands in word bits 7:0
  ofs_low_word_a: assert property (
    wr_ofs_lo && pstrb[1] |-> ##2 chan_offset.word[7:0] == $past(pwdata[15:8], 2))
    else $error("offset low not joined");
  // gain high half reaches the joined word
  gain_high_word_a: assert property (
    wr_gain_hi && pstrb[1:0] == 2'h3 |-> ##2 chan_gain.word[23:8] == $past(pwdata[15:0], 2))
    else $error("gain high not joined");
  // gain low byte lands in word bits 7:0
  gain_low_word_a: assert property (
    wr_gain_lo && pstrb[1] |-> ##2 chan_gain.word[7:0] == $past(pwdata[15:8], 2))
    else $error("gain low not joined");
  // gain update pulse follows a half write by exactly two edges
  cal_update_a: assert property (
    chan_gain.upd == $past(wr_gain_hi || wr_gain_lo, 2))
    else $error("gain update pulse wrong");
  // offset update pulse follows a half write by exactly two edges
  ofs_update_a: assert property (
    chan_offset.upd == $past(wr_ofs_hi || wr_ofs_lo, 2))
    else $error("offset update pulse wrong");
  // previous channel byte is written from lane one
  prev_low_a: assert property (
    wr_prev && pstrb[1] |=> prev_chan_gain_low == $past(pwdata[15:8]))
    else $error("previous gain low not written");
  // global filter field follows lane zero
  global_dc_a: assert property (
    wr_gdc && pstrb[0] |=> global_dc_filter_setting == $past(pwdata[3:0]))
    else $error("global filter setting not written");
  // the answer comes one cycle after setup and lasts one cycle
  answer_once_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("answer timing wrong");

  // main scenarios
  gain_write_c: cover property (wr_gain_hi ##[1:8] wr_gain_lo);
  dc_off_c: cover property (wr_cfg && pstrb[0] && pwdata[2]);
  cfg_read_c: cover property (pready && !pwrite && $past(idx) == `IDX_CFG);
  unmapped_c: cover property (pready && pslverr);
  back_to_back_c: cover property (acc_wr ##1 setup ##1 acc_wr);
endmodule : adc_channel_cal_config_regs
`default_nettype wire

// >>> test/adc_channel_cal_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_consts.svh"
module adc_channel_cal_config_regs_tb_top
  import adc_cal_pkg::*;
;
  // clock, reset and apb master side
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  // design outputs
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  chan_cfg_s   chan_cfg;
  logic [3:0]  global_dc_filter_setting;
  cal_word_s   chan_offset;
  cal_word_s   chan_gain;
  logic [7:0]  prev_chan_gain_low;
  // bench state
  int          n_mismatch;
  int          num_checks;
  int          cycles;
  int          seed_v;
  logic [31:0] rd_v;
  logic        err_v;
  logic [15:0] shadow [7];  // expected contents, one per register

  // register index table, order matches shadow
  localparam logic [9:0] IDX_TAB [7] = '{`IDX_PREV_GAIN_LOW, `IDX_CFG, `IDX_OFS_HIGH,
    `IDX_OFS_LOW, `IDX_GAIN_HIGH, `IDX_GAIN_LOW, `IDX_GLOBAL_DC};

  adc_channel_cal_config_regs #(.ADDR_W(12)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .chan_cfg(chan_cfg),
    .global_dc_filter_setting(global_dc_filter_setting), .chan_offset(chan_offset),
    .chan_gain(chan_gain), .prev_chan_gain_low(prev_chan_gain_low)
  );

  // 10 mhz clock
  always #50 pclk = ~pclk;

  // writable bits of each register; reserved bits read zero
  function automatic logic [15:0] mask_of(input int i);
    case (i)
      1: mask_of = 16'hffc7;
      2, 4: mask_of = 16'hffff;
      6: mask_of = 16'h000f;
      default: mask_of = 16'hff00;
    endcase
  endfunction : mask_of

  // one comparison of a value
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  // one comparison of a flag
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  // one apb transfer; holds the request until pready is seen, takes data there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is sampled at each rising edge; the wait has no limit of its own, the hang guard ends a stuck run
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk_val("wait states", 32'h0, 32'(n));
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // write a register and track what it should hold afterwards
  task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, {IDX_TAB[i], 2'h0}, d, s, rd_v, err_v);
    chk_bit("write slverr", 1'b0, err_v);
    if (s[1]) shadow[i][15:8] = d[15:8];
    if (s[0]) shadow[i][7:0] = d[7:0];
    shadow[i] = shadow[i] & mask_of(i);
  endtask : wr_reg

  // read a register back; upper half of the bus is always zero
  task automatic rd_chk(input int i);
    apb(1'b0, {IDX_TAB[i], 2'h0}, 32'h0, 4'h0, rd_v, err_v);
    chk_val("read data", {16'h0, shadow[i]}, rd_v);
    chk_bit("read slverr", 1'b0, err_v);
  endtask : rd_chk

  // datapath outputs; joined words settle one edge after the commit
  task automatic chk_outs();
    repeat (3) @(negedge pclk);
    chk_val("chan cfg", {19'h0, shadow[1][15:6], shadow[1][2], shadow[1][1:0]},
            {19'h0, chan_cfg});
    chk_val("offset word", {8'h0, shadow[2], shadow[3][15:8]},
            {8'h0, chan_offset.word});
    chk_val("gain word", {8'h0, shadow[4], shadow[5][15:8]},
            {8'h0, chan_gain.word});
    chk_val("prev gain low", {24'h0, shadow[0][15:8]}, {24'h0, prev_chan_gain_low});
    chk_val("global dc", {28'h0, shadow[6][3:0]}, {28'h0, global_dc_filter_setting});
  endtask : chk_outs

  // update pulse must stand in the second cycle after the commit only
  task automatic chk_upd(input string nm, input logic ofs);
    logic [2:0] seen;
    for (int n = 0; n < 3; n++) begin
      @(negedge pclk);
      seen[n] = ofs ? chan_offset.upd : chan_gain.upd;
    end
    chk_val(nm, 32'h2, {29'h0, seen});
  endtask : chk_upd

  // expect reset contents everywhere
  task automatic rst_chk();
    for (int i = 0; i < 7; i++) begin
      shadow[i] = (i == 4) ? `RST_GAIN_HIGH : 16'h0000;
      rd_chk(i);
    end
    chk_outs();
  endtask : rst_chk

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // hang guard; the whole run needs well under two thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    seed_v = $urandom(99579);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rst_chk();
    $display("test reset values done");
    // every input selection, with reserved cfg bits forced high on write
    for (int k = 0; k < 4; k++) begin
      wr_reg(1, ($urandom() & 32'hfffffff8) | 32'h38 | k | ((k % 2) << 2), 4'h3);
      rd_chk(1);
      chk_outs();
    end
    $display("test config fields done");
    // gain word at its largest factor, then an update pulse on a half write
    wr_reg(4, 32'h0000ffff, 4'h3);
    wr_reg(5, 32'h0000ffff, 4'h3);
    chk_upd("gain update", 1'b0);
    chk_outs();
    chk_val("gain max", 32'h00ffffff, {8'h0, chan_gain.word});
    rd_chk(5);
    // only the upper lane strobed; lower lane keeps its value
    wr_reg(4, 32'h00001234, 4'h2);
    rd_chk(4);
    wr_reg(3, 32'h0000a5c3, 4'h2);
    chk_upd("offset update", 1'b1);
    rd_chk(3);
    chk_outs();
    $display("test gain corners done");
    // unmapped and misaligned places are refused and store nothing
    apb(1'b0, 12'hffc, 32'h0, 4'h0, rd_v, err_v);
    chk_bit("unmapped slverr", 1'b1, err_v);
    chk_val("unmapped data", 32'h0, rd_v);
    apb(1'b1, {IDX_TAB[1], 2'h1}, 32'h0000ffff, 4'hf, rd_v, err_v);
    chk_bit("misaligned slverr", 1'b1, err_v);
    rd_chk(1);
    $display("test refused access done");
    // random traffic over all registers and lanes
    for (int t = 0; t < 40; t++) begin
      wr_reg($urandom_range(6), $urandom(), 4'($urandom()));
      if (t % 4 == 3) rd_chk($urandom_range(6));
    end
    for (int i = 0; i < 7; i++) rd_chk(i);
    chk_outs();
    $display("test random traffic done");
    // reset in mid-run returns everything to its reset value
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rst_chk();
    $display("test second reset done");
    test_done();
  end
endmodule : adc_channel_cal_config_regs_tb_top
`default_nettype wire
